// [efc_flow_port.sv]
`timescale 1ns/100ps
// How it works
// (RULE_01) Auto mode: hardware owns flow enable and pause request; only high threshold decides.
// (RULE_02) Manual mode: host drives pause request, jam enable and flow enable itself.
// (RULE_03) Host keeps the receive queue size at two units or more.
// (RULE_04) Host keeps high threshold between one and below queue size.
// (RULE_05) Auto flow control is on after reset; host may clear it.
// (RULE_06) Low threshold is status only, never gates pause or jam.
// (RULE_07) Full duplex: one pause per frame received while above high threshold.
// (RULE_08) Host should program 80 slots of 64 bytes as pause time.
// (RULE_09) Pause frames use destination 01-80-62-00-00-01.
// (RULE_10) Host should set thresholds about 96 packets apart.
// (RULE_11) Overflow sets a sticky flag and frames are dropped meanwhile.
// (RULE_12) Host bit decides whether far-end pause frames halt our transmitter.
// (RULE_13) Transmit queue gets no automatic flow control.
// (RULE_14) Half duplex: jam first 4 bytes of each new frame while jamming.
// (RULE_15) Frame in progress at crossing not jammed; stop below threshold.
// (RULE_16) Received pause shows in unsupported and control frame status bits; code sets only the control bit for it.
// (RULE_17) RMII selected by pin: seven signals, 50 MHz reference; code drives reference_clock_out at 2.5 MHz, or clock_in/2 at 100 Mbit/s.
// (RULE_18) MII selected by pin: 17 signals, 25 MHz reference; code drives reference_clock_out at 2.5 MHz, or clock_in/2 at 100 Mbit/s.
// (RULE_19) MII DCE: device drives TX and RX clocks from the reference.
// (RULE_20) MII DTE: PHY drives TX and RX clocks as inputs.
// (RULE_21) Frames longer than programmed maximum, up to 2016 bytes, are rejected.
// (RULE_22) Maximum length in bits is the register value times 8.
// (RULE_23) Frame status words are overwritten by each completed frame.
module efc_flow_port (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic hsel_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic [31:0] hwdata_in,
   input wire logic hready_in,
   output logic hreadyout_out,
   output logic [31:0] hrdata_out,
   output logic hresp_out,
   input wire logic reduced_iface_select_pin_in,
   input wire logic dce_role_pin_in,
   input wire logic mii_rx_clk_in,
   output logic mii_rx_clk_out,
   output logic mii_rx_clk_oe_n_out,
   input wire logic mii_tx_clk_in,
   output logic mii_tx_clk_out,
   output logic mii_tx_clk_oe_n_out,
   output logic reference_clock_out,
   input wire logic mii_rx_dv_in,
   input wire logic [3:0] mii_rxd_in,
   output logic mii_tx_en_out,
   output logic [3:0] mii_txd_out,
   input wire logic [7:0] rx_queue_level_in,
   input wire logic rx_queue_overflow_in,
   input wire logic tx_frame_done_in,
   input wire logic [15:0] tx_frame_status_in,
   output logic pause_send_out,
   output logic [15:0] pause_time_out,
   output logic [47:0] pause_dest_out,
   output logic tx_pause_hold_out,
   output logic rx_frame_accept_out,
   output logic rx_frame_reject_out,
   output logic flow_ctrl_enable_out,
   output logic jam_active_out
);
   import efc_pkg::*;

   logic [GCR_W-1:0] gcr;
   logic flow_en_reg, busy_reg, ovf;
   logic [15:0] ptime;
   logic [7:0] qsize, qhigh, qlow;
   logic [LEN_W-1:0] mfs;
   logic [15:0] txst;
   logic [31:0] rxst;
   logic wr_pend;
   logic [7:0] wr_addr;
   logic [PIN_W-1:0] pin_s1, pin_s2;
   logic [1:0] clk_s3;
   logic [3:0] div_cnt;
   logic gen_clk, gen_rise;
   logic [3:0] jam_cnt;
   logic rx_sof, rx_eof, too_long, ctrl_f, unsup_f;
   logic [LEN_W-1:0] rx_len;
   logic [31:0] rd_mux;

   // Pins cross into clock_in through two flops; edges look at s2 and s3 only
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         clk_s3 <= 2'h0;
      end else begin
         pin_s1 <= {mii_rx_clk_in, mii_tx_clk_in, mii_rx_dv_in, mii_rxd_in,
                    reduced_iface_select_pin_in, dce_role_pin_in};
         pin_s2 <= pin_s1;
         clk_s3 <= pin_s2[8:7];
      end
   end
   wire s_dce = pin_s2[0];
   wire s_rmii = pin_s2[1];
   wire [3:0] s_rxd = pin_s2[5:2];
   wire s_dv = pin_s2[6];
   wire rx_pin_rise = pin_s2[8] & ~clk_s3[1];
   wire tx_pin_rise = pin_s2[7] & ~clk_s3[0];
   wire dce_mii = s_dce & ~s_rmii; // see (RULE_18)

   // 10 Mbit/s clock is exact; 100 Mbit/s is capped at clock_in/2 here
   wire [3:0] half_per = gcr[GCR_SPEED100] ? FAST_HALF : SLOW_HALF;
   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         div_cnt <= 4'h0;
         gen_clk <= 1'b0;
         gen_rise <= 1'b0;
      end else begin
         gen_rise <= 1'b0;
         if (div_cnt + 4'h1 >= half_per) begin
            div_cnt <= 4'h0;
            gen_clk <= ~gen_clk;
            gen_rise <= ~gen_clk;
         end else begin
            div_cnt <= div_cnt + 4'h1;
         end
      end
   end
   assign reference_clock_out = gen_clk; // see (RULE_17)
   assign mii_rx_clk_out = gen_clk; // see (RULE_19)
   assign mii_tx_clk_out = gen_clk; // see (RULE_19)
   assign mii_rx_clk_oe_n_out = ~dce_mii; // see (RULE_20)
   assign mii_tx_clk_oe_n_out = ~dce_mii; // see (RULE_20)
   wire rx_tick = dce_mii ? gen_rise : rx_pin_rise;
   wire tx_tick = dce_mii ? gen_rise : tx_pin_rise;

   efc_rx_mon u_rx (
      .clock_in(clock_in),
      .rst_in(rst_in),
      .tick_in(rx_tick),
      .dv_in(s_dv),
      .rxd_in(s_rxd),
      .max_len_in(mfs),
      .sof_out(rx_sof),
      .eof_out(rx_eof),
      .len_out(rx_len),
      .too_long_out(too_long),
      .ctrl_out(ctrl_f),
      .unsup_out(unsup_f)
   );

   // Only the receive queue feeds flow control; see (RULE_13)
   wire auto = gcr[GCR_AUTO];
   wire fdx = gcr[GCR_FDX];
   wire above_high = rx_queue_level_in > qhigh;
   wire below_low = rx_queue_level_in < qlow; // see (RULE_06)
   wire flow_en_eff = auto | flow_en_reg; // see (RULE_01)
   wire jam_req = auto ? above_high : gcr[GCR_JAM]; // see (RULE_01)
   wire jam_active = flow_en_eff & ~fdx & jam_req;
   wire pause_fire = flow_en_eff & fdx & (auto ? (rx_eof & above_high) : busy_reg); // see (RULE_07)

   // Bus write lands in the data phase; hready is always high
   wire addr_ok = hsel_in & hready_in & htrans_in[1];
   wire do_wr = wr_pend;
   wire wr_gcr = do_wr && wr_addr == A_GCR;
   wire wr_fcr = do_wr && wr_addr == A_FCR;
   wire ovf_clr = do_wr && wr_addr == A_QSTAT && hwdata_in[QS_OVF];

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         wr_pend <= 1'b0;
         wr_addr <= 8'h00;
         gcr <= GCR_RST; // see (RULE_05)
         flow_en_reg <= 1'b0;
         busy_reg <= 1'b0;
         ptime <= PAUSE_TIME_RST;
         qsize <= QSIZE_RST;
         qhigh <= QHIGH_RST;
         qlow <= QLOW_RST;
         mfs <= MAX_FRAME_RST;
         ovf <= 1'b0;
      end else begin
         wr_pend <= addr_ok & hwrite_in;
         wr_addr <= haddr_in[7:0];
         if (wr_gcr) gcr <= hwdata_in[GCR_W-1:0];
         if (wr_fcr) ptime <= hwdata_in[FCR_TIME +: 16];
         if (wr_fcr && !auto) flow_en_reg <= hwdata_in[FCR_FLOW_EN]; // see (RULE_01)
         // A new request beats the clear so none is lost; turning auto on drops it
         if (wr_fcr && hwdata_in[FCR_BUSY] && !auto) busy_reg <= 1'b1;
         else if (pause_fire || auto || (wr_gcr && hwdata_in[GCR_AUTO])) busy_reg <= 1'b0;
         if (do_wr && wr_addr == A_QSIZE) qsize <= hwdata_in[7:0];
         if (do_wr && wr_addr == A_QHIGH) qhigh <= hwdata_in[7:0];
         if (do_wr && wr_addr == A_QLOW) qlow <= hwdata_in[7:0];
         if (do_wr && wr_addr == A_MFSH) mfs[LEN_W-1:8] <= hwdata_in[LEN_W-9:0];
         if (do_wr && wr_addr == A_MFSL) mfs[7:0] <= hwdata_in[7:0];
         // Set wins over a simultaneous clear
         if (rx_queue_overflow_in) ovf <= 1'b1; // see (RULE_11)
         else if (ovf_clr) ovf <= 1'b0;
      end
   end

   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (haddr_in[7:0])
         A_GCR: rd_mux[GCR_W-1:0] = gcr;
         A_FCR: rd_mux = {ptime, 14'h0000, auto ? pause_send_out : busy_reg, flow_en_eff};
         A_QSIZE: rd_mux[7:0] = qsize;
         A_QHIGH: rd_mux[7:0] = qhigh;
         A_QLOW: rd_mux[7:0] = qlow;
         A_QSTAT: rd_mux[2:0] = {below_low, above_high, ovf};
         A_MFSH: rd_mux[LEN_W-9:0] = mfs[LEN_W-1:8];
         A_MFSL: rd_mux[7:0] = mfs[7:0];
         A_TXST: rd_mux[15:0] = txst;
         A_RXST: rd_mux = rxst;
         A_PINS: rd_mux[1:0] = {s_dce, s_rmii}; // see (RULE_17)
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         hrdata_out <= 32'h0000_0000;
         txst <= 16'h0000;
         rxst <= 32'h0000_0000;
         pause_send_out <= 1'b0;
         tx_pause_hold_out <= 1'b0;
         rx_frame_accept_out <= 1'b0;
         rx_frame_reject_out <= 1'b0;
         jam_cnt <= 4'h0;
      end else begin
         if (addr_ok && !hwrite_in) hrdata_out <= rd_mux;
         if (tx_frame_done_in) txst <= tx_frame_status_in; // see (RULE_23)
         if (rx_eof) rxst <= {6'h00, unsup_f, ctrl_f, 8'h00, 3'h0, too_long, rx_len}; // see (RULE_23)
         pause_send_out <= pause_fire; // see (RULE_07)
         tx_pause_hold_out <= rx_eof & ctrl_f & ~unsup_f & gcr[GCR_HONOUR]; // see (RULE_12)
         rx_frame_reject_out <= rx_eof & (too_long | rx_queue_overflow_in); // see (RULE_21)
         rx_frame_accept_out <= rx_eof & ~too_long & ~rx_queue_overflow_in; // see (RULE_11)
         // Decided at start of frame, so a frame already running is spared
         if (rx_sof && jam_active && jam_cnt == 4'h0) jam_cnt <= JAM_NIBBLES; // see (RULE_15)
         else if (tx_tick && jam_cnt != 4'h0) jam_cnt <= jam_cnt - 4'h1; // see (RULE_14)
      end
   end

   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign mii_tx_en_out = jam_cnt != 4'h0;
   assign mii_txd_out = JAM_NIB;
   assign pause_time_out = ptime;
   assign pause_dest_out = PAUSE_DA; // see (RULE_09)
   assign flow_ctrl_enable_out = flow_en_eff;
   assign jam_active_out = jam_active;

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);

   property p_auto_fce;
      auto |-> flow_ctrl_enable_out && !busy_reg;
   endproperty
   a_auto_fce: assert property (p_auto_fce) else $error("auto mode lost flow enable"); // see (RULE_01)
   property p_manual_pause;
      !auto && fdx && flow_en_eff && busy_reg |=> pause_send_out;
   endproperty
   a_manual_pause: assert property (p_manual_pause) else $error("manual pause lost"); // see (RULE_02)
   property p_reset_auto;
      $past(rst_in) |-> gcr[GCR_AUTO];
   endproperty
   a_reset_auto: assert property (p_reset_auto) else $error("auto flow off after reset"); // see (RULE_05)
   property p_pause_per_frame;
      auto && fdx && rx_eof && above_high |=> pause_send_out ##1 !pause_send_out;
   endproperty
   a_pause_per_frame: assert property (p_pause_per_frame) else $error("no pause"); // see (RULE_07)
   property p_pause_cause;
      pause_send_out |-> $past(fdx) && $past(auto ? rx_eof && above_high : busy_reg);
   endproperty
   a_pause_cause: assert property (p_pause_cause) else $error("stray pause"); // see (RULE_06)
   property p_dest;
      pause_send_out |-> pause_dest_out == PAUSE_DA;
   endproperty
   a_dest: assert property (p_dest) else $error("bad pause address"); // see (RULE_09)
   property p_ovf;
      rx_queue_overflow_in |=> ovf [*2];
   endproperty
   a_ovf: assert property (p_ovf) else $error("overflow flag not held"); // see (RULE_11)
   property p_drop;
      rx_eof && rx_queue_overflow_in |=> rx_frame_reject_out && !rx_frame_accept_out;
   endproperty
   a_drop: assert property (p_drop) else $error("frame kept in overflow"); // see (RULE_11)
   property p_jam_start;
      rx_sof && jam_active && jam_cnt == 4'h0 |=> mii_tx_en_out && jam_cnt == JAM_NIBBLES;
   endproperty
   a_jam_start: assert property (p_jam_start) else $error("jam not started"); // see (RULE_14)
   property p_jam_only_sof;
      $rose(mii_tx_en_out) |-> $past(rx_sof) && $past(jam_active);
   endproperty
   a_jam_only_sof: assert property (p_jam_only_sof) else $error("jam mid frame"); // see (RULE_15)
   property p_clk_role;
      dce_mii |-> !mii_rx_clk_oe_n_out && !mii_tx_clk_oe_n_out;
   endproperty
   a_clk_role: assert property (p_clk_role) else $error("DCE clocks not driven"); // see (RULE_19)
   property p_too_long;
      rx_eof && too_long |=> rx_frame_reject_out ##1 rxst[LEN_W];
   endproperty
   a_too_long: assert property (p_too_long) else $error("long frame kept"); // see (RULE_21)
   property p_status;
      rx_eof |=> rxst[LEN_W-1:0] == $past(rx_len);
   endproperty
   a_status: assert property (p_status) else $error("rx status not updated"); // see (RULE_23)

   c_pause: cover property (pause_send_out);
   c_jam: cover property ($rose(mii_tx_en_out));
   c_reject: cover property (rx_frame_reject_out);
   c_far_pause: cover property (tx_pause_hold_out);
endmodule

// [efc_phy_model.sv]
`timescale 1ns/100ps
module efc_phy_model (
   output logic rx_clk_out,
   output logic tx_clk_out,
   output logic dv_out,
   output logic [3:0] rxd_out
);
   import efc_pkg::*;
   initial begin
      rx_clk_out = 1'b0;
      tx_clk_out = 1'b0;
      dv_out = 1'b0;
      rxd_out = 4'h0;
   end
   // Clocks stand still between frames; idle data is the inverse of the last nibble
   task automatic nib(input logic v, input logic [3:0] d);
      dv_out = v;
      rxd_out = v ? d : ~rxd_out;
      #200 rx_clk_out = 1'b1;
      tx_clk_out = 1'b1;
      #200 rx_clk_out = 1'b0;
      tx_clk_out = 1'b0;
   endtask
   task automatic send_frame(input logic [7:0] fb [$]);
      #7;
      for (int i = 0; i < 15; i++) nib(1'b1, 4'h5);
      nib(1'b1, SFD_NIB);
      foreach (fb[i]) begin
         nib(1'b1, fb[i][3:0]);
         nib(1'b1, fb[i][7:4]);
      end
      // Idle gap long enough for the status and jam to finish
      for (int i = 0; i < 24; i++) nib(1'b0, 4'h0);
   endtask
endmodule

// [efc_pkg.sv]
package efc_pkg;
   // Bus map, byte addresses
   localparam logic [7:0] A_GCR = 8'h00;
   localparam logic [7:0] A_FCR = 8'h04;
   localparam logic [7:0] A_QSIZE = 8'h08;
   localparam logic [7:0] A_QHIGH = 8'h0C;
   localparam logic [7:0] A_QLOW = 8'h10;
   localparam logic [7:0] A_QSTAT = 8'h14;
   localparam logic [7:0] A_MFSH = 8'h18;
   localparam logic [7:0] A_MFSL = 8'h1C;
   localparam logic [7:0] A_TXST = 8'h20;
   localparam logic [7:0] A_RXST = 8'h24;
   localparam logic [7:0] A_PINS = 8'h28;
   // general_control_reg fields
   localparam int GCR_AUTO = 0;
   localparam int GCR_JAM = 1;
   localparam int GCR_FDX = 2;
   localparam int GCR_HONOUR = 3;
   localparam int GCR_SPEED100 = 4;
   localparam int GCR_W = 5;
   localparam logic [GCR_W-1:0] GCR_RST = 5'h01;
   // mac_flow_ctrl_reg fields
   localparam int FCR_FLOW_EN = 0;
   localparam int FCR_BUSY = 1;
   localparam int FCR_TIME = 16;
   localparam logic [15:0] PAUSE_TIME_RST = 16'h0050;
   // rx_queue_latched_status fields
   localparam int QS_OVF = 0;
   localparam int QS_HIGH = 1;
   localparam int QS_LOW = 2;
   localparam logic [7:0] QSIZE_RST = 8'h20;
   localparam logic [7:0] QHIGH_RST = 8'h1F;
   localparam logic [7:0] QLOW_RST = 8'h01;
   // Frame length in bytes
   localparam int LEN_W = 12;
   localparam logic [LEN_W-1:0] MAX_FRAME_RST = 12'h7E0;
   localparam logic [47:0] PAUSE_DA = 48'h0180_6200_0001;
   localparam logic [15:0] CTRL_TYPE = 16'h8808;
   // Byte positions after the start delimiter
   localparam int DA_LEN = 6;
   localparam int TYPE_POS = 12;
   localparam logic [3:0] SFD_NIB = 4'hD;
   localparam logic [3:0] JAM_NIB = 4'h5;
   localparam int JAM_BYTES = 4;
   localparam logic [3:0] JAM_NIBBLES = 4'(2 * JAM_BYTES);
   // Link clock generation in the DCE role
   localparam int CLK_HZ = 20_000_000;
   localparam int SLOW_LINK_HZ = 2_500_000;
   localparam logic [3:0] SLOW_HALF = 4'(CLK_HZ / (2 * SLOW_LINK_HZ));
   localparam logic [3:0] FAST_HALF = 4'h1;
   localparam int PIN_W = 9;
   typedef enum logic [1:0] {RX_IDLE, RX_PRE, RX_DATA} efc_rx_e;
endpackage

// [efc_rx_mon.sv]
`timescale 1ns/100ps
module efc_rx_mon (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic tick_in,
   input wire logic dv_in,
   input wire logic [3:0] rxd_in,
   input wire logic [efc_pkg::LEN_W-1:0] max_len_in,
   output logic sof_out,
   output logic eof_out,
   output logic [efc_pkg::LEN_W-1:0] len_out,
   output logic too_long_out,
   output logic ctrl_out,
   output logic unsup_out
);
   import efc_pkg::*;

   efc_rx_e state;
   logic half;
   logic [3:0] lo_nib;
   logic [LEN_W-1:0] cnt;
   logic [7:0] type_hi;
   logic da_miss;
   logic is_ctrl;
   wire [7:0] rx_byte = {rxd_in, lo_nib};
   wire cnt_full = &cnt;

   function automatic logic [7:0] da_byte(input logic [LEN_W-1:0] idx);
      da_byte = PAUSE_DA[8 * (DA_LEN - 1 - int'(idx)) +: 8];
   endfunction

   always_ff @(posedge clock_in) begin
      sof_out <= 1'b0;
      eof_out <= 1'b0;
      if (rst_in) begin
         state <= RX_IDLE;
         half <= 1'b0;
         lo_nib <= 4'h0;
         cnt <= '0;
         type_hi <= 8'h00;
         da_miss <= 1'b0;
         is_ctrl <= 1'b0;
         len_out <= '0;
         too_long_out <= 1'b0;
         ctrl_out <= 1'b0;
         unsup_out <= 1'b0;
      end else if (tick_in) begin
         unique case (state)
            RX_IDLE: begin
               if (dv_in) begin
                  sof_out <= 1'b1;
                  state <= RX_PRE;
                  cnt <= '0;
                  half <= 1'b0;
                  da_miss <= 1'b0;
                  is_ctrl <= 1'b0;
               end
            end
            RX_PRE: begin
               if (!dv_in) begin
                  eof_out <= 1'b1;
                  state <= RX_IDLE;
               end else if (rxd_in == SFD_NIB) begin
                  state <= RX_DATA;
               end
            end
            RX_DATA: begin
               if (!dv_in) begin
                  // Counts DA through CRC, preamble excluded; see (RULE_21)
                  eof_out <= 1'b1;
                  state <= RX_IDLE;
                  len_out <= cnt;
                  too_long_out <= cnt > max_len_in; // see (RULE_22)
                  ctrl_out <= is_ctrl; // see (RULE_16)
                  unsup_out <= is_ctrl & da_miss; // see (RULE_16)
               end else if (!half) begin
                  lo_nib <= rxd_in;
                  half <= 1'b1;
               end else begin
                  half <= 1'b0;
                  // Saturates so a runaway frame still reads as too long
                  if (!cnt_full) cnt <= cnt + 1'b1;
                  if (cnt < DA_LEN && rx_byte != da_byte(cnt)) da_miss <= 1'b1; // see (RULE_09)
                  if (cnt == TYPE_POS) type_hi <= rx_byte;
                  if (cnt == TYPE_POS + 1) is_ctrl <= {type_hi, rx_byte} == CTRL_TYPE;
               end
            end
         endcase
      end
   end
endmodule

// [tb_ethernet_port_flow_control.sv]
`timescale 1ns/100ps
module tb_ethernet_port_flow_control;
   import efc_pkg::*;
   typedef struct {string nm; logic [47:0] e; logic [47:0] m;} efc_note_s;
   logic clock_in = 1'b0, rst_in = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_ph = 1'b0;
   logic rmii = 1'b0, dce = 1'b0, ovf = 1'b0, tdone = 1'b0, e, e_rx;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
   logic [1:0] htrans = 2'b00;
   logic [7:0] level = 8'h00, seed = 8'h1C;
   logic [15:0] txst = 16'h0, ptime;
   logic hready, hresp, rxc_o, rxc_oe_n, txc_o, txc_oe_n, refc, txen, psend, phold;
   logic acc, rej, fc_en, jam, prx, ptx, pdv;
   logic [3:0] txd, prxd;
   logic [47:0] pdest;
   wire logic rxc = rxc_oe_n ? prx : rxc_o;
   wire logic txc = txc_oe_n ? ptx : txc_o;
   localparam logic [47:0] DA_U = 48'h0000_1111_2222;
   efc_note_s q_rd[$];
   logic q_rx[$];
   int errors = 0, n_checks = 0, n_pause = 0, n_hold = 0, n_jam = 0, h;
   initial forever #25 clock_in = ~clock_in;
   efc_phy_model phy (.rx_clk_out(prx), .tx_clk_out(ptx), .dv_out(pdv), .rxd_out(prxd));
   efc_flow_port dut (.clock_in(clock_in), .rst_in(rst_in), .hsel_in(hsel),
      .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'b010),
      .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready), .hrdata_out(hrdata),
      .hresp_out(hresp), .reduced_iface_select_pin_in(rmii), .dce_role_pin_in(dce),
      .mii_rx_clk_in(rxc), .mii_rx_clk_out(rxc_o), .mii_rx_clk_oe_n_out(rxc_oe_n),
      .mii_tx_clk_in(txc), .mii_tx_clk_out(txc_o), .mii_tx_clk_oe_n_out(txc_oe_n),
      .reference_clock_out(refc), .mii_rx_dv_in(pdv), .mii_rxd_in(prxd),
      .mii_tx_en_out(txen), .mii_txd_out(txd), .rx_queue_level_in(level),
      .rx_queue_overflow_in(ovf), .tx_frame_done_in(tdone), .tx_frame_status_in(txst),
      .pause_send_out(psend), .pause_time_out(ptime), .pause_dest_out(pdest),
      .tx_pause_hold_out(phold), .rx_frame_accept_out(acc), .rx_frame_reject_out(rej),
      .flow_ctrl_enable_out(fc_en), .jam_active_out(jam));
   task automatic chk(input string nm, input logic [47:0] ex, input logic [47:0] g);
      n_checks++;
      if (g !== ex) begin
         errors++;
         $display("mismatch %s expected %h seen %h", nm, ex, g);
      end
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Outputs sampled before the edge's own updates land
   always @(posedge clock_in) begin
      if (rd_ph) begin
         chk(q_rd[0].nm, q_rd[0].e, {15'h0, hresp, hrdata} & q_rd[0].m);
         void'(q_rd.pop_front());
      end
      if (acc === 1'b1 || rej === 1'b1) begin
         e_rx = (q_rx.size() > 0) ? q_rx.pop_front() : 1'bx;
         chk("rx_accept", {47'h0, e_rx}, {47'h0, acc});
      end
      if (psend === 1'b1) n_pause++;
      if (phold === 1'b1) n_hold++;
   end
   always @(posedge txc) if (txen === 1'b1) n_jam++;
   task automatic wait_rdy();
      int k;
      k = 0;
      do begin
         @(posedge clock_in);
         k++;
      end while (hready !== 1'b1 && k < 64);
      if (k >= 64) chk("hready", 1, 0);
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock_in);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {24'h0, a};
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      rd_ph <= ~w;
      wait_rdy();
      rd_ph <= 1'b0;
   endtask
   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] x,
                     input logic [31:0] m);
      q_rd.push_back('{nm, {16'h0, x & m}, {16'h1, m}});
      bus(1'b0, a, 32'h0);
   endtask
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   task automatic frame(input int len, input logic [47:0] da, input logic [15:0] ty,
                        input logic ok);
      logic [7:0] fb[$];
      for (int i = 0; i < len; i++) begin
         seed = lfsr(seed);
         fb.push_back(i < 6 ? da[47 - 8 * i -: 8] : i == 12 ? ty[15:8] : i == 13 ? ty[7:0] : seed);
      end
      q_rx.push_back(ok);
      @(posedge clock_in);
      phy.send_frame(fb);
      @(posedge clock_in);
   endtask
   initial begin
      #3_000_000;
      errors++;
      report_and_stop();
   end
   initial begin
      repeat (5) @(posedge clock_in);
      rst_in <= 1'b0;
      rd("gcr", A_GCR, {27'h0, GCR_RST}, 32'h0000_001F);
      rd("ptime_reg", A_FCR, {PAUSE_TIME_RST, 16'h0}, 32'hFFFF_0000);
      rd("qsize", A_QSIZE, {24'h0, QSIZE_RST}, 32'h0000_00FF);
      rd("qhigh", A_QHIGH, {24'h0, QHIGH_RST}, 32'h0000_00FF);
      rd("qlow", A_QLOW, {24'h0, QLOW_RST}, 32'h0000_00FF);
      rd("mfs_high", A_MFSH, {28'h0, MAX_FRAME_RST[11:8]}, 32'h0000_000F);
      rd("mfs_low", A_MFSL, {24'h0, MAX_FRAME_RST[7:0]}, 32'h0000_00FF);
      rd("unmapped", 8'h2C, 32'h0, 32'hFFFF_FFFF);
      chk("flow_en_rst", 1, fc_en);
      chk("pause_dest", PAUSE_DA, pdest);
      $display("test reset done");
      bus(1'b1, A_MFSH, 32'h0);
      bus(1'b1, A_MFSL, 32'h0000_0040);
      frame(64, DA_U, 16'h0800, 1'b1);
      rd("rx_len", A_RXST, 32'h0000_0040, 32'h0000_1FFF);
      frame(65, DA_U, 16'h0800, 1'b0);
      rd("rx_long", A_RXST, 32'h0000_1041, 32'h0000_1FFF);
      $display("test length done");
      ovf <= 1'b1;
      frame(64, DA_U, 16'h0800, 1'b0);
      ovf <= 1'b0;
      rd("ovf_flag", A_QSTAT, 32'h1, 32'h1);
      bus(1'b1, A_QSTAT, 32'h1);
      rd("ovf_clear", A_QSTAT, 32'h0, 32'h1);
      $display("test overflow done");
      bus(1'b1, A_GCR, 32'h0000_0005);
      bus(1'b1, A_FCR, {PAUSE_TIME_RST, 16'h0});
      bus(1'b1, A_QLOW, 32'h0000_0030);
      level <= 8'h20;
      frame(64, DA_U, 16'h0800, 1'b1);
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("pause_count", 2, n_pause);
      chk("flow_en_auto", 1, fc_en);
      chk("ptime", PAUSE_TIME_RST, ptime);
      rd("qstat_levels", A_QSTAT, 32'h6, 32'h7);
      level <= 8'h1F;
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("pause_at_high", 2, n_pause);
      level <= 8'h20;
      bus(1'b1, A_GCR, 32'h0000_0004);
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("pause_manual_none", 2, n_pause);
      bus(1'b1, A_FCR, {PAUSE_TIME_RST, 16'h0003});
      repeat (4) @(posedge clock_in);
      chk("pause_manual", 3, n_pause);
      bus(1'b1, A_FCR, {PAUSE_TIME_RST, 16'h0});
      repeat (4) @(posedge clock_in);
      chk("flow_en_manual_off", 0, fc_en);
      $display("test pause done");
      bus(1'b1, A_GCR, 32'h0000_000C);
      frame(64, PAUSE_DA, CTRL_TYPE, 1'b1);
      chk("hold_on", 1, n_hold);
      rd("rx_ctrl", A_RXST, 32'h0100_0000, 32'h0300_0000);
      bus(1'b1, A_GCR, 32'h0000_0004);
      frame(64, PAUSE_DA, CTRL_TYPE, 1'b1);
      frame(64, DA_U, CTRL_TYPE, 1'b1);
      chk("hold_off", 1, n_hold);
      rd("rx_unsup", A_RXST, 32'h0200_0000, 32'h0200_0000);
      $display("test honour done");
      bus(1'b1, A_GCR, 32'h0000_0001);
      level <= 8'h10;
      n_jam = 0;
      fork
         frame(64, DA_U, 16'h0800, 1'b1);
         begin
            repeat (300) @(posedge clock_in);
            level <= 8'h20;
         end
      join
      chk("jam_current", 0, n_jam);
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("jam_next", 2 * JAM_BYTES, n_jam);
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("jam_again", 4 * JAM_BYTES, n_jam);
      level <= 8'h10;
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("jam_stop", 4 * JAM_BYTES, n_jam);
      chk("jam_idle", 0, jam);
      bus(1'b1, A_GCR, 32'h0000_0002);
      bus(1'b1, A_FCR, {PAUSE_TIME_RST, 16'h0001});
      @(posedge clock_in);
      chk("jam_manual_on", 1, jam);
      frame(64, DA_U, 16'h0800, 1'b1);
      chk("jam_manual", 6 * JAM_BYTES, n_jam);
      chk("jam_nibble", JAM_NIB, txd);
      $display("test jam done");
      repeat (2) begin
         @(posedge clock_in);
         seed = lfsr(seed);
         txst <= {seed, ~seed};
         tdone <= 1'b1;
         @(posedge clock_in);
         tdone <= 1'b0;
      end
      rd("tx_status", A_TXST, {16'h0, seed, ~seed}, 32'h0000_FFFF);
      dce <= 1'b1;
      repeat (8) @(posedge clock_in);
      chk("oe_dce", 0, txc_oe_n);
      for (int s = 0; s < 2; s++) begin
         bus(1'b1, A_GCR, s ? 32'h0000_0011 : 32'h0000_0001);
         repeat (2) begin
            e = txc_o;
            h = 0;
            while (txc_o === e && h < 50) begin
               @(posedge clock_in);
               h++;
            end
         end
         chk("clk_half", s ? FAST_HALF : SLOW_HALF, h);
      end
      rmii <= 1'b1;
      repeat (8) @(posedge clock_in);
      chk("oe_rmii", 1, txc_oe_n);
      rd("pins", A_PINS, 32'h3, 32'h3);
      chk("ref_rx_clk", {txc_o, txc_o}, {refc, rxc_o});
      rmii <= 1'b0;
      dce <= 1'b0;
      repeat (8) @(posedge clock_in);
      chk("oe_dte", 1, rxc_oe_n);
      $display("test clocking done");
      report_and_stop();
   end
endmodule
